// ===== switch_node_pkg.sv
package switch_node_pkg;

   // ****************************************************************
   // Register numbers
   // ****************************************************************
   localparam logic [7:0] REG_NODE_IDENTIFICATION = 8'h00;
   localparam logic [7:0] REG_SWITCH_DESCRIPTION = 8'h01;
   localparam logic [7:0] REG_SWITCH_PROTECT_AND_HEADER = 8'h04;
   localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
   localparam logic [7:0] REG_PLL_SETTINGS = 8'h06;
   localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
   localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
   localparam logic [7:0] REG_SCAN_IDENTITY = 8'h09;
   localparam logic [7:0] REG_USER_CODE = 8'h0A;
   localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW = 8'h0C;
   localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH = 8'h0D;
   localparam logic [7:0] REG_TILE0_DEBUG_LINE_CONFIG = 8'h10;
   localparam logic [7:0] REG_TILE1_DEBUG_LINE_CONFIG = 8'h11;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int NODE_ID_W = 16;
   localparam int DIR_W = 4;
   localparam int DIM_IDX_W = 4;
   localparam int DIV_W = 16;
   localparam int TILES = 2;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PROT_ALL_BIT = 31;
   localparam int PROT_PLL_BIT = 8;
   localparam int HEADER_MODE_BIT = 0;
   localparam int PLL_NO_RESET_BIT = 31;
   localparam int PLL_NO_RELOCK_BIT = 30;
   localparam int PLL_BYPASS_BIT = 29;
   localparam int PLL_BOOT_JTAG_BIT = 28;
   localparam int PLL_OUT_DIV_LSB = 23;
   localparam int PLL_OUT_DIV_W = 3;
   localparam int PLL_MUL_LSB = 8;
   localparam int PLL_MUL_W = 13;
   localparam int PLL_IN_DIV_LSB = 0;
   localparam int PLL_IN_DIV_W = 7;
   localparam int DBG_REQ_EN_BIT = 1;
   localparam int DBG_DRIVE_EN_BIT = 0;
   localparam int IDENT_BOOT_LSB = 16;
   localparam int IDENT_REV_LSB = 8;
   localparam int IDENT_VER_LSB = 0;
   localparam int BYTE_W = 8;
   localparam int USER_OTP_LSB = 18;
   localparam int USER_OTP_W = 14;
   localparam int USER_FIX_W = 18;

   // ****************************************************************
   // Writable masks and reset values
   // ****************************************************************
   localparam logic [31:0] PROT_MASK = 32'h8000_0101;
   localparam logic [31:0] NODE_ID_MASK = 32'h0000_FFFF;
   localparam logic [31:0] PLL_MASK = 32'hF39F_FF7F;
   localparam logic [31:0] DIV_MASK = 32'h0000_FFFF;
   localparam logic [31:0] DBG_MASK = 32'h0000_0003;
   localparam logic [31:0] PROT_RESET = 32'h0000_0000;
   localparam logic [31:0] NODE_ID_RESET = 32'h0000_0000;
   localparam logic [31:0] SWITCH_DIV_RESET = 32'h0000_0000;
   localparam logic [31:0] REF_DIV_RESET = 32'h0000_0003;
   localparam logic [31:0] DIRS_RESET = 32'h0000_0000;
   localparam logic [31:0] DBG_RESET = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ===== route_if.sv
`timescale 1ns/1ps
interface route_if;
   import switch_node_pkg::*;

   logic [NODE_ID_W-1:0] own_id;
   logic [NODE_ID_W-1:0] dest_id;
   logic [2*DATA_W-1:0] dirs;
   logic [DIR_W-1:0] direction;
   logic [DIM_IDX_W-1:0] dimension;
   logic local_hit;

   modport requester (output own_id, output dest_id, output dirs,
                      input direction, input dimension, input local_hit);
   modport selector (input own_id, input dest_id, input dirs,
                     output direction, output dimension, output local_hit);
endinterface

// ===== route_select.sv
`timescale 1ns/1ps
module route_select
   import switch_node_pkg::*;
(
   route_if.selector rt
);

   logic [NODE_ID_W-1:0] mismatch;
   logic [DIM_IDX_W-1:0] top_dim;

   // ****************************************************************
   // Most significant mismatching identifier bit
   // ****************************************************************
   assign mismatch = rt.own_id ^ rt.dest_id;

   // Ascending scan, so the highest set bit wins [R15]
   always_comb
   begin
      top_dim = '0;
      for (int i = 0; i < NODE_ID_W; i++)
      begin
         if (mismatch[i])
         begin
            top_dim = DIM_IDX_W'(i);
         end
      end
   end

   // Direction field of that dimension, four bits per dimension [R15]
   assign rt.dimension = top_dim;
   assign rt.direction = rt.dirs[top_dim*DIR_W +: DIR_W];
   assign rt.local_hit = (mismatch == '0); // Packet is for this node

endmodule // route_select

// ===== switch_node_config_regs.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Protect bit 31 set blocks every write to the switch configuration registers.
// [R2] Protect bit 8 set makes the PLL settings register ignore writes.
// [R3] Protect bit 0 selects header length: 0 two-byte, 1 one-byte; resets 0.
// [R4] Sixteen-bit writable node identifier in bits 15:0, resets 0, rest read-only.
// [R5] Any accepted PLL settings write resets the tile unless suppressed.
// [R6] PLL write with bit 31 set does not reset the chip.
// [R7] PLL write with bit 30 set skips waiting for PLL re-lock.
// [R8] PLL bit 29 set bypasses the PLL, passing the input clock through.
// [R9] PLL bit 28 set makes the device boot from the scan port.
// [R10] PLL fields: output divider 25:23, multiplier 20:8, input divider 6:0.
// [R11] Sixteen-bit switch clock divider field, resets to zero.
// [R12] Sixteen-bit reference clock divider field, resets to three.
// [R13] Identification returns captured boot pins, revision and version, read-only.
// [R14] Description reports link count, switch processors and device processors, read-only.
// [R15] Route by direction of most significant mismatching node identifier bit.
// [R16] Low directions: eight four-bit fields, dimension 7 at top, reset zero.
// [R17] High directions: dimensions F down to 8, top field to lowest.
// [R18] Debug config bit 1 lets the shared halt line request processor debug.
// [R19] Debug config bit 0 lets the halted flag drive the shared halt line.
// [R20] User code returns programmed value 31:18 and fixable code 17:0.
// [R21] Reserved bits read zero and ignore writes.
module switch_node_config_regs
   import switch_node_pkg::*;
#(
   parameter logic [7:0] SWITCH_VERSION = 8'h01,  // Arbitrary value
   parameter logic [7:0] SWITCH_REVISION = 8'h02, // Arbitrary value
   parameter logic [7:0] LINK_COUNT = 8'h08,
   parameter logic [7:0] SWITCH_PROCESSORS = 8'h02,
   parameter logic [7:0] DEVICE_PROCESSORS = 8'h02,
   parameter logic [31:0] SCAN_IDENTITY = 32'h1234_5671, // Arbitrary value
   parameter logic [13:0] USER_OTP_CODE = 14'h0000,
   parameter logic [17:0] USER_FIXED_CODE = 18'h00000,  // Arbitrary value
   parameter logic [31:0] PLL_RESET = 32'h0000_0000
)
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Configuration access
   input wire logic cfg_wr_in,
   input wire logic cfg_rd_in,
   input wire logic [ADDR_W-1:0] cfg_addr_in,
   input wire logic [DATA_W-1:0] cfg_wdata_in,
   output logic [DATA_W-1:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   output logic cfg_wr_refused_out,
   // Boot straps
   input wire logic [7:0] boot_select_pins_in,
   // Switch settings
   output logic header_one_byte_out,
   output logic [NODE_ID_W-1:0] node_id_out,
   output logic [DIV_W-1:0] switch_clk_div_out,
   output logic [DIV_W-1:0] ref_clk_div_out,
   // PLL control
   output logic [PLL_OUT_DIV_W-1:0] pll_output_divider_out,
   output logic [PLL_MUL_W-1:0] pll_multiplier_out,
   output logic [PLL_IN_DIV_W-1:0] pll_input_divider_out,
   output logic pll_bypass_out,
   output logic boot_from_scan_out,
   output logic pll_update_out,
   output logic pll_wait_relock_out,
   output logic tile_reset_out,
   // Routing lookup
   input wire logic route_req_in,
   input wire logic [NODE_ID_W-1:0] route_dest_id_in,
   output logic route_valid_out,
   output logic [DIR_W-1:0] route_direction_out,
   output logic [DIM_IDX_W-1:0] route_dimension_out,
   output logic route_local_out,
   // Shared halt line
   input wire logic shared_halt_line_in,
   input wire logic [TILES-1:0] processor_halted_flag_in,
   output logic [TILES-1:0] debug_request_out,
   output logic shared_halt_assert_out
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [DATA_W-1:0] switch_protect_and_header, node_identifier, pll_settings;
   logic [DATA_W-1:0] switch_clock_divider, reference_clock_divider;
   logic [DATA_W-1:0] route_directions_low, route_directions_high;
   logic [DATA_W-1:0] tile_debug_line_config [TILES];
   logic [7:0] boot_capture;
   logic boot_captured;

   // ****************************************************************
   // Decode
   // ****************************************************************
   logic all_locked, pll_locked, wr_ok, wr_refused;
   logic sel_prot, sel_node, sel_pll, sel_sdiv, sel_rdiv, sel_dlow, sel_dhigh, sel_dbg0, sel_dbg1;
   logic wr_prot, wr_node, wr_pll, wr_sdiv, wr_rdiv, wr_dlow, wr_dhigh, wr_dbg0, wr_dbg1;

   // Lock bits taken from the protect register
   assign all_locked = switch_protect_and_header[PROT_ALL_BIT];
   assign pll_locked = switch_protect_and_header[PROT_PLL_BIT];

   // Register selection by number
   assign sel_prot = (cfg_addr_in == REG_SWITCH_PROTECT_AND_HEADER);
   assign sel_node = (cfg_addr_in == REG_NODE_IDENTIFIER);
   assign sel_pll = (cfg_addr_in == REG_PLL_SETTINGS);
   assign sel_sdiv = (cfg_addr_in == REG_SWITCH_CLOCK_DIVIDER);
   assign sel_rdiv = (cfg_addr_in == REG_REFERENCE_CLOCK_DIVIDER);
   assign sel_dlow = (cfg_addr_in == REG_ROUTE_DIRECTIONS_LOW);
   assign sel_dhigh = (cfg_addr_in == REG_ROUTE_DIRECTIONS_HIGH);
   assign sel_dbg0 = (cfg_addr_in == REG_TILE0_DEBUG_LINE_CONFIG);
   assign sel_dbg1 = (cfg_addr_in == REG_TILE1_DEBUG_LINE_CONFIG);

   // Global write lock, including the protect register itself
   assign wr_ok = cfg_wr_in & ~all_locked; // [R1]

   // Write strobes per register
   assign wr_prot = wr_ok & sel_prot;
   assign wr_node = wr_ok & sel_node;
   assign wr_pll = wr_ok & sel_pll & ~pll_locked; // [R2]
   assign wr_sdiv = wr_ok & sel_sdiv;
   assign wr_rdiv = wr_ok & sel_rdiv;
   assign wr_dlow = wr_ok & sel_dlow;
   assign wr_dhigh = wr_ok & sel_dhigh;
   assign wr_dbg0 = wr_ok & sel_dbg0;
   assign wr_dbg1 = wr_ok & sel_dbg1;

   // Write to a writable register blocked by a lock
   assign wr_refused = cfg_wr_in & (all_locked | (sel_pll & pll_locked))
                     & (sel_prot | sel_node | sel_pll | sel_sdiv | sel_rdiv
                        | sel_dlow | sel_dhigh | sel_dbg0 | sel_dbg1);

   // ****************************************************************
   // Read data selection
   // ****************************************************************
   logic [DATA_W-1:0] ident_word, descr_word, user_word, next_rdata;

   // Read-only words assembled from straps and constants
   assign ident_word = {8'h00, boot_capture, SWITCH_REVISION, SWITCH_VERSION}; // [R13]
   assign descr_word = {8'h00, LINK_COUNT, SWITCH_PROCESSORS, DEVICE_PROCESSORS}; // [R14]
   assign user_word = {USER_OTP_CODE, USER_FIXED_CODE}; // [R20]

   // Unmapped numbers read as zero
   always_comb
   begin
      case (cfg_addr_in)
         REG_NODE_IDENTIFICATION: next_rdata = ident_word;
         REG_SWITCH_DESCRIPTION: next_rdata = descr_word;
         REG_SWITCH_PROTECT_AND_HEADER: next_rdata = switch_protect_and_header;
         REG_NODE_IDENTIFIER: next_rdata = node_identifier;
         REG_PLL_SETTINGS: next_rdata = pll_settings;
         REG_SWITCH_CLOCK_DIVIDER: next_rdata = switch_clock_divider;
         REG_REFERENCE_CLOCK_DIVIDER: next_rdata = reference_clock_divider;
         REG_SCAN_IDENTITY: next_rdata = SCAN_IDENTITY;
         REG_USER_CODE: next_rdata = user_word;
         REG_ROUTE_DIRECTIONS_LOW: next_rdata = route_directions_low;
         REG_ROUTE_DIRECTIONS_HIGH: next_rdata = route_directions_high;
         REG_TILE0_DEBUG_LINE_CONFIG: next_rdata = tile_debug_line_config[0];
         REG_TILE1_DEBUG_LINE_CONFIG: next_rdata = tile_debug_line_config[1];
         default: next_rdata = ZERO_WORD;
      endcase
   end

   // ****************************************************************
   // Boot strap capture
   // ****************************************************************
   // Straps are caught on the first edge after reset release
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         boot_captured <= 1'b0;
         boot_capture <= 8'h00;
      end
      else if (!boot_captured)
      begin
         boot_captured <= 1'b1;
         boot_capture <= boot_select_pins_in; // [R13]
      end
   end

   // ****************************************************************
   // Writable registers
   // ****************************************************************
   // Protect and header mode; only masked bits store [R21]
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         switch_protect_and_header <= PROT_RESET; // [R3]
      else if (wr_prot)
         switch_protect_and_header <= cfg_wdata_in & PROT_MASK; // [R1] [R2] [R3]
   end

   // PLL settings fields and control bits
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         pll_settings <= PLL_RESET & PLL_MASK;
      else if (wr_pll)
         pll_settings <= cfg_wdata_in & PLL_MASK; // [R10] [R21]
   end

   // Identifier, dividers, direction tables and halt line set-up
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         node_identifier <= NODE_ID_RESET;
         switch_clock_divider <= SWITCH_DIV_RESET; // [R11]
         reference_clock_divider <= REF_DIV_RESET; // [R12]
         route_directions_low <= DIRS_RESET; // [R16]
         route_directions_high <= DIRS_RESET; // [R17]
         tile_debug_line_config[0] <= DBG_RESET; // [R18] [R19]
         tile_debug_line_config[1] <= DBG_RESET;
      end
      else
      begin
         if (wr_node)
            node_identifier <= cfg_wdata_in & NODE_ID_MASK; // [R4]
         if (wr_sdiv)
            switch_clock_divider <= cfg_wdata_in & DIV_MASK; // [R11]
         if (wr_rdiv)
            reference_clock_divider <= cfg_wdata_in & DIV_MASK; // [R12]
         if (wr_dlow)
            route_directions_low <= cfg_wdata_in; // [R16]
         if (wr_dhigh)
            route_directions_high <= cfg_wdata_in; // [R17]
         if (wr_dbg0)
            tile_debug_line_config[0] <= cfg_wdata_in & DBG_MASK;
         if (wr_dbg1)
            tile_debug_line_config[1] <= cfg_wdata_in & DBG_MASK;
      end
   end

   // ****************************************************************
   // Read answer
   // ****************************************************************
   // Read data answers one cycle after the strobe
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         cfg_rdata_out <= ZERO_WORD;
         cfg_rvalid_out <= 1'b0;
         cfg_wr_refused_out <= 1'b0;
      end
      else
      begin
         cfg_rvalid_out <= cfg_rd_in;
         cfg_wr_refused_out <= wr_refused;
         if (cfg_rd_in)
            cfg_rdata_out <= next_rdata; // [R21]
      end
   end

   // ****************************************************************
   // Switch and PLL outputs
   // ****************************************************************
   logic next_tile_reset, next_wait_relock;

   // Accepted PLL write resets the tile unless the write suppresses it
   assign next_tile_reset = wr_pll & ~cfg_wdata_in[PLL_NO_RESET_BIT]; // [R5] [R6]
   assign next_wait_relock = wr_pll & ~cfg_wdata_in[PLL_NO_RELOCK_BIT]; // [R7]

   // Levels follow the stored settings; pulses mark the accepted write
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         header_one_byte_out <= 1'b0;
         node_id_out <= '0;
         switch_clk_div_out <= '0;
         ref_clk_div_out <= '0;
         pll_output_divider_out <= '0;
         pll_multiplier_out <= '0;
         pll_input_divider_out <= '0;
         pll_bypass_out <= 1'b0;
         boot_from_scan_out <= 1'b0;
         pll_update_out <= 1'b0;
         pll_wait_relock_out <= 1'b0;
         tile_reset_out <= 1'b0;
      end
      else
      begin
         header_one_byte_out <= switch_protect_and_header[HEADER_MODE_BIT]; // [R3]
         node_id_out <= node_identifier[NODE_ID_W-1:0]; // [R4]
         switch_clk_div_out <= switch_clock_divider[DIV_W-1:0]; // [R11]
         ref_clk_div_out <= reference_clock_divider[DIV_W-1:0]; // [R12]
         pll_output_divider_out <= pll_settings[PLL_OUT_DIV_LSB +: PLL_OUT_DIV_W]; // [R10]
         pll_multiplier_out <= pll_settings[PLL_MUL_LSB +: PLL_MUL_W]; // [R10]
         pll_input_divider_out <= pll_settings[PLL_IN_DIV_LSB +: PLL_IN_DIV_W]; // [R10]
         pll_bypass_out <= pll_settings[PLL_BYPASS_BIT]; // [R8]
         boot_from_scan_out <= pll_settings[PLL_BOOT_JTAG_BIT]; // [R9]
         pll_update_out <= wr_pll;
         pll_wait_relock_out <= next_wait_relock; // [R7]
         tile_reset_out <= next_tile_reset; // [R5] [R6]
      end
   end

   // ****************************************************************
   // Routing lookup
   // ****************************************************************
   route_if rt ();

   // Own identifier and both tables, dimension 15 on top
   assign rt.own_id = node_identifier[NODE_ID_W-1:0];
   assign rt.dest_id = route_dest_id_in;
   assign rt.dirs = {route_directions_high, route_directions_low}; // [R16] [R17]

   route_select u_route_select
   (
      .rt (rt)
   );

   // Registered answer one cycle after the request
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         route_valid_out <= 1'b0;
         route_direction_out <= '0;
         route_dimension_out <= '0;
         route_local_out <= 1'b0;
      end
      else
      begin
         route_valid_out <= route_req_in;
         if (route_req_in)
         begin
            route_direction_out <= rt.direction; // [R15]
            route_dimension_out <= rt.dimension;
            route_local_out <= rt.local_hit;
         end
      end
   end

   // ****************************************************************
   // Shared halt line
   // ****************************************************************
   logic [TILES-1:0] drive_terms, next_debug_request;

   // Per tile enables taken from the configuration registers
   for (genvar t = 0; t < TILES; t++)
   begin : g_tile
      assign drive_terms[t] = tile_debug_line_config[t][DBG_DRIVE_EN_BIT]
                            & processor_halted_flag_in[t]; // [R19]
      assign next_debug_request[t] = tile_debug_line_config[t][DBG_REQ_EN_BIT]
                                   & shared_halt_line_in; // [R18]
   end

   // Line assertion and debug requests, registered
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         shared_halt_assert_out <= 1'b0;
         debug_request_out <= '0;
      end
      else
      begin
         shared_halt_assert_out <= |drive_terms; // [R19]
         debug_request_out <= next_debug_request; // [R18]
      end
   end

endmodule // switch_node_config_regs

// ===== switch_node_config_regs_properties.sv
`timescale 1ns/1ps
// ****************************************************************
// Register bank properties
// ****************************************************************
module switch_node_config_regs_properties
   import switch_node_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic cfg_wr_in,
   input wire logic [ADDR_W-1:0] cfg_addr_in,
   input wire logic [DATA_W-1:0] cfg_wdata_in,
   input wire logic cfg_wr_refused_out,
   input wire logic [NODE_ID_W-1:0] node_id_out,
   input wire logic [PLL_OUT_DIV_W-1:0] pll_output_divider_out,
   input wire logic pll_bypass_out,
   input wire logic boot_from_scan_out,
   input wire logic pll_update_out,
   input wire logic pll_wait_relock_out,
   input wire logic tile_reset_out,
   input wire logic route_req_in,
   input wire logic [NODE_ID_W-1:0] route_dest_id_in,
   input wire logic route_valid_out,
   input wire logic route_local_out,
   input wire logic shared_halt_line_in,
   input wire logic [TILES-1:0] processor_halted_flag_in,
   input wire logic [TILES-1:0] debug_request_out,
   input wire logic shared_halt_assert_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   // Write effects, routing and halt line
   a_pll_write_taken: assert property (
      cfg_wr_in && cfg_addr_in == REG_PLL_SETTINGS |=> pll_update_out != cfg_wr_refused_out)
      else $error("PLL write neither applied nor refused");
   a_tile_reset_gate: assert property (
      pll_update_out |-> tile_reset_out == !$past(cfg_wdata_in[PLL_NO_RESET_BIT]))
      else $error("Tile reset pulse wrong");
   a_relock_gate: assert property (
      pll_update_out |-> pll_wait_relock_out == !$past(cfg_wdata_in[PLL_NO_RELOCK_BIT]))
      else $error("Relock wait pulse wrong");
   a_pll_fields: assert property (
      pll_update_out |=> pll_bypass_out == $past(cfg_wdata_in[29], 2)
         && boot_from_scan_out == $past(cfg_wdata_in[28], 2)
         && pll_output_divider_out == $past(cfg_wdata_in[25:23], 2))
      else $error("PLL fields not applied");
   a_node_id_write: assert property (
      cfg_wr_in && cfg_addr_in == REG_NODE_IDENTIFIER ##1 !cfg_wr_refused_out
         |=> node_id_out == $past(cfg_wdata_in[15:0], 2))
      else $error("Node identifier not applied");
   a_route_answer: assert property (
      route_req_in |=> route_valid_out)
      else $error("Route answer missing");
   a_local_route: assert property (
      route_req_in && route_dest_id_in == node_id_out && !$past(cfg_wr_in) |=> route_local_out)
      else $error("Own identifier not routed locally");
   a_halt_quiet: assert property (
      processor_halted_flag_in == 2'h0 |=> !shared_halt_assert_out)
      else $error("Halt line driven without halted tile");
   a_request_quiet: assert property (
      !shared_halt_line_in |=> debug_request_out == 2'h0)
      else $error("Debug request without halt line");
   a_refuse_cause: assert property (
      cfg_wr_refused_out |-> $past(cfg_wr_in))
      else $error("Refusal without write");

   // Main scenarios
   c_no_reset: cover property (pll_update_out && !tile_reset_out);
   c_refused: cover property (cfg_wr_refused_out);
   c_local: cover property (route_valid_out && route_local_out);
endmodule // switch_node_config_regs_properties

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
// ****************************************************************
// Register bank testbench
// ****************************************************************
module tb_top;
   import switch_node_pkg::*;
   logic sys_clk_in = 0, rst_in = 1, cfg_wr_in = 0, cfg_rd_in = 0;
   logic route_req_in = 0, shared_halt_line_in = 0;
   logic [7:0] cfg_addr_in = 8'h00, boot_select_pins_in = 8'hA5;
   logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out;
   logic [15:0] route_dest_id_in = 16'h0, node_id_out, switch_clk_div_out, ref_clk_div_out;
   logic [1:0] processor_halted_flag_in = 2'h0, debug_request_out;
   logic [2:0] pll_output_divider_out;
   logic [12:0] pll_multiplier_out;
   logic [6:0] pll_input_divider_out;
   logic [3:0] route_direction_out, route_dimension_out;
   logic cfg_rvalid_out, cfg_wr_refused_out, header_one_byte_out, pll_bypass_out;
   logic boot_from_scan_out, pll_update_out, pll_wait_relock_out, tile_reset_out;
   logic route_valid_out, route_local_out, shared_halt_assert_out;
   int bad_count = 0, n_tests = 0;

   switch_node_config_regs uut (.*);

   // Clock and register access
   always #25 sys_clk_in = ~sys_clk_in;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      cfg_wr_in <= 1'b1;
      cfg_addr_in <= a;
      cfg_wdata_in <= d;
      @(posedge sys_clk_in);
      cfg_wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk_in);
      cfg_rd_in <= 1'b1;
      cfg_addr_in <= a;
      @(posedge sys_clk_in);
      cfg_rd_in <= 1'b0;
      #1;
      `CHK(cfg_rvalid_out, 1'b1)
      `CHK(cfg_rdata_out, e)
   endtask

   // Reset values, identity and reserved bits
   task automatic t_values;
      rd(REG_SWITCH_PROTECT_AND_HEADER, 32'h0);
      rd(REG_NODE_IDENTIFIER, 32'h0);
      rd(REG_REFERENCE_CLOCK_DIVIDER, 32'h3);
      rd(REG_ROUTE_DIRECTIONS_HIGH, 32'h0);
      rd(REG_TILE0_DEBUG_LINE_CONFIG, 32'h0);
      wr(REG_NODE_IDENTIFICATION, 32'hFFFF_FFFF);
      rd(REG_NODE_IDENTIFICATION, 32'h00A5_0201);
      rd(REG_SWITCH_DESCRIPTION, 32'h0008_0202);
      rd(REG_USER_CODE, 32'h0);
      rd(8'h02, 32'h0);
      wr(REG_SWITCH_CLOCK_DIVIDER, 32'hFFFF_FFFF);
      rd(REG_SWITCH_CLOCK_DIVIDER, 32'h0000_FFFF);
      wr(REG_REFERENCE_CLOCK_DIVIDER, 32'hABCD_1234);
      rd(REG_REFERENCE_CLOCK_DIVIDER, 32'h0000_1234);
      `CHK({switch_clk_div_out, ref_clk_div_out}, 32'hFFFF_1234)
   endtask

   // PLL writes with and without suppression
   task automatic t_pll;
      logic [31:0] d = 32'h2B9A_BC55;
      wr(REG_PLL_SETTINGS, d);
      `CHK({pll_update_out, tile_reset_out, pll_wait_relock_out}, 3'b111)
      @(posedge sys_clk_in);
      #1;
      `CHK({pll_bypass_out, boot_from_scan_out, pll_output_divider_out}, {d[29:28], d[25:23]})
      `CHK({pll_multiplier_out, pll_input_divider_out}, {d[20:8], d[6:0]})
      rd(REG_PLL_SETTINGS, d & 32'hF39F_FF7F);
      wr(REG_PLL_SETTINGS, 32'hDC60_43AA);
      `CHK({pll_update_out, tile_reset_out, pll_wait_relock_out}, 3'b100)
   endtask

   // Every routing dimension and the local case
   task automatic t_route;
      logic [15:0] dest;
      wr(REG_NODE_IDENTIFIER, 32'hFFFF_1234);
      wr(REG_ROUTE_DIRECTIONS_LOW, 32'h7654_3210);
      wr(REG_ROUTE_DIRECTIONS_HIGH, 32'hFEDC_BA98);
      rd(REG_NODE_IDENTIFIER, 32'h0000_1234);
      for (int d = 0; d < 17; d++)
      begin
         dest = (d == 16) ? 16'h1234 : 16'h1234 ^ ((16'h2 << d) - 16'h1);
         @(posedge sys_clk_in);
         route_req_in <= 1'b1;
         route_dest_id_in <= dest;
         @(posedge sys_clk_in);
         route_req_in <= 1'b0;
         #1;
         `CHK({route_valid_out, route_local_out}, {1'b1, d == 16})
         `CHK({route_direction_out, route_dimension_out}, {d[3:0], d[3:0]})
      end
   endtask

   // Shared halt line in both directions
   task automatic t_debug;
      wr(REG_TILE0_DEBUG_LINE_CONFIG, 32'h2);
      wr(REG_TILE1_DEBUG_LINE_CONFIG, 32'hFFFF_FFFD);
      rd(REG_TILE1_DEBUG_LINE_CONFIG, 32'h1);
      @(posedge sys_clk_in);
      shared_halt_line_in <= 1'b1;
      processor_halted_flag_in <= 2'b10;
      repeat (2) @(posedge sys_clk_in);
      #1;
      `CHK({debug_request_out, shared_halt_assert_out}, 3'b011)
      @(posedge sys_clk_in);
      processor_halted_flag_in <= 2'b01;
      repeat (2) @(posedge sys_clk_in);
      #1;
      `CHK(shared_halt_assert_out, 1'b0)
   endtask

   // Write locks, kept last since the full lock holds until reset
   task automatic t_locks;
      wr(REG_SWITCH_PROTECT_AND_HEADER, 32'h0000_0100);
      wr(REG_PLL_SETTINGS, 32'h0);
      `CHK({cfg_wr_refused_out, pll_update_out}, 2'b10)
      rd(REG_PLL_SETTINGS, 32'hD000_432A);
      wr(REG_SWITCH_PROTECT_AND_HEADER, 32'hFFFF_FFFF);
      rd(REG_SWITCH_PROTECT_AND_HEADER, 32'h8000_0101);
      `CHK(header_one_byte_out, 1'b1)
      wr(REG_NODE_IDENTIFIER, 32'h0);
      `CHK(cfg_wr_refused_out, 1'b1)
      rd(REG_NODE_IDENTIFIER, 32'h0000_1234);
   endtask

   // Verdict
   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_values();
      t_pll();
      t_route();
      t_debug();
      t_locks();
      report_and_stop();
   end
endmodule // tb_top

bind switch_node_config_regs switch_node_config_regs_properties chk (.*);
